// File: hdl/port_bc_pad_function_mux.sv
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
// Contract
// - B1 selects pwm_ch1_out, spi mosi, radio pa
// - B2 selects pwm_ch2_out, spi miso, cts, twi clk
// - B3 selects pwm_ch0_out, spi clk, rts, twi data
// - B4 selects inverted pwm_ch1_out or uart tx
// - B5 selects pwm_ch4_out or uart rx
// - B6 selects inverted pwm_ch0_out, twi clk, rts
// - B7 selects pwm_ch1_out, twi data, cts
// - C1 selects inverted pwm_ch2_out only
// - C2 defaults to spi slave select
// - C3 defaults to spi slave data out
// - C4 defaults to spi slave data in
// - C5 defaults to spi slave clock
// - C6 selects pwm_ch4_out only
// - C7 defaults to debug wire, else pwm_ch3_out
// - port b per-pin gpio control bits
// - port c per-pin gpio control bits
// - input gate high passes pad input
// - output disable high releases pad driver on gpio pins only
// - gpio enable overrides function selector
// - drive level resets strong, applies driving
module port_bc_pad_function_mux #(
  parameter int ADDR_W = pad_mux_pkg::ADDR_W
) (
  input  wire logic                              core_clk_in,
  input  wire logic                              resetn_in,
  // apb slave
  input  wire logic                              psel_in,
  input  wire logic                              penable_in,
  input  wire logic                              pwrite_in,
  input  wire logic [ADDR_W-1:0]                 paddr_in,
  input  wire logic [pad_mux_pkg::DATA_W-1:0]    pwdata_in,
  input  wire logic [3:0]                        pstrb_in,
  output logic      [pad_mux_pkg::DATA_W-1:0]    prdata_out,
  output logic                                   pready_out,
  output logic                                   pslverr_out,
  // pads
  input  wire logic [7:0]                        port_b_pins_in,
  output logic      [7:0]                        port_b_pins_out,
  output logic      [7:0]                        port_b_pins_oe_out,
  output logic      [7:0]                        port_b_drive_level_out,
  input  wire logic [7:0]                        port_c_pins_in,
  output logic      [7:0]                        port_c_pins_out,
  output logic      [7:0]                        port_c_pins_oe_out,
  output logic      [7:0]                        port_c_drive_level_out,
  // peripherals
  input  wire logic [pad_mux_pkg::FN_COUNT-1:0]  periph_out_in,
  input  wire logic [pad_mux_pkg::FN_COUNT-1:0]  periph_oe_in,
  output logic      [pad_mux_pkg::FN_COUNT-1:0]  periph_in_out,
  output logic      [pad_mux_pkg::PIN_COUNT-1:0] pin_event_out
);

  localparam int NP = pad_mux_pkg::PIN_COUNT;
  localparam int NF = pad_mux_pkg::FN_COUNT;

  // ---------------- apb decode ----------------
  logic [pad_mux_pkg::REG_IDX_W-1:0] reg_idx;
  logic                              setup_phase;
  logic                              wr_en;
  logic [7:0]                        wdata;

  assign reg_idx     = paddr_in[pad_mux_pkg::REG_IDX_W+1:2];
  assign setup_phase = psel_in & ~penable_in;
  assign wr_en       = psel_in & penable_in & pwrite_in & pstrb_in[0];
  assign wdata       = pwdata_in[7:0];
  assign pready_out  = 1'b1;

  logic hit_pb_in, hit_pb_ie, hit_pb_oen, hit_pb_out, hit_pb_pol, hit_pb_ds, hit_pb_gpio;
  logic hit_pc_in, hit_pc_ie, hit_pc_oen, hit_pc_out, hit_pc_pol, hit_pc_ds, hit_pc_gpio;
  logic hit_pb_lo, hit_pb_hi, hit_pc_lo, hit_pc_hi, hit_any;

  assign hit_pb_in   = reg_idx == pad_mux_pkg::IDX_PB_INPUT_LEVEL;
  assign hit_pb_ie   = reg_idx == pad_mux_pkg::IDX_PB_INPUT_GATE;
  assign hit_pb_oen  = reg_idx == pad_mux_pkg::IDX_PB_OUTPUT_DISABLE;
  assign hit_pb_out  = reg_idx == pad_mux_pkg::IDX_PB_OUTPUT_VALUE;
  assign hit_pb_pol  = reg_idx == pad_mux_pkg::IDX_PB_POLARITY;
  assign hit_pb_ds   = reg_idx == pad_mux_pkg::IDX_PB_DRIVE_LEVEL;
  assign hit_pb_gpio = reg_idx == pad_mux_pkg::IDX_PB_GPIO_SELECT;
  assign hit_pc_in   = reg_idx == pad_mux_pkg::IDX_PC_INPUT_LEVEL;
  assign hit_pc_ie   = reg_idx == pad_mux_pkg::IDX_PC_INPUT_GATE;
  assign hit_pc_oen  = reg_idx == pad_mux_pkg::IDX_PC_OUTPUT_DISABLE;
  assign hit_pc_out  = reg_idx == pad_mux_pkg::IDX_PC_OUTPUT_VALUE;
  assign hit_pc_pol  = reg_idx == pad_mux_pkg::IDX_PC_POLARITY;
  assign hit_pc_ds   = reg_idx == pad_mux_pkg::IDX_PC_DRIVE_LEVEL;
  assign hit_pc_gpio = reg_idx == pad_mux_pkg::IDX_PC_GPIO_SELECT;
  assign hit_pb_lo   = reg_idx == pad_mux_pkg::IDX_PB_LOW_FUNC;
  assign hit_pb_hi   = reg_idx == pad_mux_pkg::IDX_PB_HIGH_FUNC;
  assign hit_pc_lo   = reg_idx == pad_mux_pkg::IDX_PC_LOW_FUNC;
  assign hit_pc_hi   = reg_idx == pad_mux_pkg::IDX_PC_HIGH_FUNC;
  assign hit_any     = hit_pb_in | hit_pb_ie | hit_pb_oen | hit_pb_out | hit_pb_pol
                     | hit_pb_ds | hit_pb_gpio | hit_pc_in | hit_pc_ie | hit_pc_oen
                     | hit_pc_out | hit_pc_pol | hit_pc_ds | hit_pc_gpio
                     | hit_pb_lo | hit_pb_hi | hit_pc_lo | hit_pc_hi;

  // ---------------- control registers ----------------
  logic [7:0] pb_ie_reg, pb_oen_reg, pb_out_reg, pb_pol_reg, pb_ds_reg, pb_gpio_reg;
  logic [7:0] pc_ie_reg, pc_oen_reg, pc_out_reg, pc_pol_reg, pc_ds_reg, pc_gpio_reg;
  logic [7:0] pb_lo_reg, pb_hi_reg, pc_lo_reg, pc_hi_reg;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pb_ie_reg   <= pad_mux_pkg::RST_PB_INPUT_GATE;
      pb_oen_reg  <= pad_mux_pkg::RST_OUTPUT_DISABLE;
      pb_out_reg  <= pad_mux_pkg::RST_OUTPUT_VALUE;
      pb_pol_reg  <= pad_mux_pkg::RST_POLARITY;
      pb_ds_reg   <= pad_mux_pkg::RST_DRIVE_LEVEL;
      pb_gpio_reg <= pad_mux_pkg::RST_PB_GPIO_SELECT;
    end else if (wr_en) begin
      if (hit_pb_ie)   pb_ie_reg   <= wdata;
      if (hit_pb_oen)  pb_oen_reg  <= wdata;
      if (hit_pb_out)  pb_out_reg  <= wdata;
      if (hit_pb_pol)  pb_pol_reg  <= wdata;
      if (hit_pb_ds)   pb_ds_reg   <= wdata;
      if (hit_pb_gpio) pb_gpio_reg <= wdata;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pc_ie_reg   <= pad_mux_pkg::RST_PC_INPUT_GATE;
      pc_oen_reg  <= pad_mux_pkg::RST_OUTPUT_DISABLE;
      pc_out_reg  <= pad_mux_pkg::RST_OUTPUT_VALUE;
      pc_pol_reg  <= pad_mux_pkg::RST_POLARITY;
      pc_ds_reg   <= pad_mux_pkg::RST_DRIVE_LEVEL;
      pc_gpio_reg <= pad_mux_pkg::RST_PC_GPIO_SELECT;
    end else if (wr_en) begin
      if (hit_pc_ie)   pc_ie_reg   <= wdata;
      if (hit_pc_oen)  pc_oen_reg  <= wdata;
      if (hit_pc_out)  pc_out_reg  <= wdata;
      if (hit_pc_pol)  pc_pol_reg  <= wdata;
      if (hit_pc_ds)   pc_ds_reg   <= wdata;
      if (hit_pc_gpio) pc_gpio_reg <= wdata;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pb_lo_reg <= pad_mux_pkg::RST_FUNC_SELECT;
      pb_hi_reg <= pad_mux_pkg::RST_FUNC_SELECT;
      pc_lo_reg <= pad_mux_pkg::RST_FUNC_SELECT;
      pc_hi_reg <= pad_mux_pkg::RST_FUNC_SELECT;
    end else if (wr_en) begin
      if (hit_pb_lo) pb_lo_reg <= wdata;
      if (hit_pb_hi) pb_hi_reg <= wdata;
      if (hit_pc_lo) pc_lo_reg <= wdata;
      if (hit_pc_hi) pc_hi_reg <= wdata;
    end
  end

  // ---------------- pad input sync ----------------
  logic [NP-1:0] pad_sync;
  logic [NP-1:0] ie_all, oen_all, out_all, pol_all, ds_all, gpio_all;
  logic [NP-1:0] gated_in;

  level_sync #(
    .WIDTH (NP)
  ) u_pad_sync (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .level_in    ({port_c_pins_in, port_b_pins_in}),
    .level_out   (pad_sync)
  );

  assign ie_all   = {pc_ie_reg, pb_ie_reg};
  assign oen_all  = {pc_oen_reg, pb_oen_reg};
  assign out_all  = {pc_out_reg, pb_out_reg};
  assign pol_all  = {pc_pol_reg, pb_pol_reg};
  assign ds_all   = {pc_ds_reg, pb_ds_reg};
  assign gpio_all = {pc_gpio_reg, pb_gpio_reg};
  assign gated_in = pad_sync & ie_all & pad_mux_pkg::PIN_PRESENT;

  // ---------------- read mux, sampled in setup ----------------
  logic [7:0] rd_byte;

  assign rd_byte = hit_pb_in   ? gated_in[7:0]  :
                   hit_pc_in   ? gated_in[15:8] :
                   hit_pb_ie   ? pb_ie_reg   :
                   hit_pb_oen  ? pb_oen_reg  :
                   hit_pb_out  ? pb_out_reg  :
                   hit_pb_pol  ? pb_pol_reg  :
                   hit_pb_ds   ? pb_ds_reg   :
                   hit_pb_gpio ? pb_gpio_reg :
                   hit_pc_ie   ? pc_ie_reg   :
                   hit_pc_oen  ? pc_oen_reg  :
                   hit_pc_out  ? pc_out_reg  :
                   hit_pc_pol  ? pc_pol_reg  :
                   hit_pc_ds   ? pc_ds_reg   :
                   hit_pc_gpio ? pc_gpio_reg :
                   hit_pb_lo   ? pb_lo_reg   :
                   hit_pb_hi   ? pb_hi_reg   :
                   hit_pc_lo   ? pc_lo_reg   :
                   hit_pc_hi   ? pc_hi_reg   : 8'h00;

  logic [pad_mux_pkg::DATA_W-1:0] prdata_reg;
  logic                           pslverr_reg;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg  <= {24'h000000, rd_byte};
      pslverr_reg <= ~hit_any;
    end
  end

  assign prdata_out  = prdata_reg;
  assign pslverr_out = pslverr_reg & psel_in & penable_in;

  // ---------------- per-pin function mux ----------------
  logic [NP*pad_mux_pkg::SEL_W-1:0] fsel_all;
  logic [NF:0]           fn_out_ext;
  logic [NF:0]           fn_oe_ext;
  logic [NP-1:0]         pad_out_next, pad_oe_next, pad_ds_next;
  logic [NP*pad_mux_pkg::FN_W-1:0] pin_fn, pin_alt;
  logic [NP-1:0]         pin_func_mode;

  assign fsel_all   = {{pc_hi_reg, pc_lo_reg}, {pb_hi_reg, pb_lo_reg}};
  assign fn_out_ext = {1'b0, periph_out_in};
  assign fn_oe_ext  = {1'b0, periph_oe_in};

  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_pin
      logic [pad_mux_pkg::SEL_W-1:0] sel;
      logic [pad_mux_pkg::FN_W-1:0]  fn;
      logic [pad_mux_pkg::FN_W-1:0]  alt;
      logic                          fn_valid;
      logic                          func_out;
      logic                          func_oe;

      // selector sits at bits 2n+1:2n of the low/high byte
      assign sel = fsel_all[(p/4)*8 + (p%4)*2 +: pad_mux_pkg::SEL_W];
      assign fn  = pad_mux_pkg::FUNC_MAP[p][sel];
      // slave data/clock pins share code 0 with the twi slave
      assign alt = ((p == pad_mux_pkg::PIN_C_SLAVE_DATA) && (sel == 2'h0))
                   ? pad_mux_pkg::FN_TWI_SLAVE_DATA
                   : ((p == pad_mux_pkg::PIN_C_SLAVE_CLK) && (sel == 2'h0))
                   ? pad_mux_pkg::FN_TWI_SLAVE_CLK
                   : pad_mux_pkg::FN_NONE;
      assign fn_valid = fn != pad_mux_pkg::FN_NONE;
      assign func_out = fn_out_ext[fn] | fn_out_ext[alt];
      assign func_oe  = fn_valid & (fn_oe_ext[fn] | fn_oe_ext[alt]);

      assign pin_func_mode[p] = ~gpio_all[p] & pad_mux_pkg::PIN_PRESENT[p];
      assign pin_fn[p*pad_mux_pkg::FN_W +: pad_mux_pkg::FN_W]  = fn;
      assign pin_alt[p*pad_mux_pkg::FN_W +: pad_mux_pkg::FN_W] = alt;

      // gpio wins over the selector
      assign pad_out_next[p] = gpio_all[p] ? out_all[p]
                             : (fn_valid & func_out);
      assign pad_oe_next[p]  = pad_mux_pkg::PIN_PRESENT[p]
                             & (gpio_all[p] ? ~oen_all[p] : func_oe);
      assign pad_ds_next[p]  = ds_all[p] & pad_oe_next[p];
    end
  endgenerate

  // pad levels back to the selected peripheral inputs
  logic [NF-1:0] periph_in_next;

  always_comb begin
    periph_in_next = '0;
    for (int i = 0; i < NP; i++) begin
      for (int f = 0; f < NF; f++) begin
        if (pin_func_mode[i]
            && ((pin_fn[i*pad_mux_pkg::FN_W +: pad_mux_pkg::FN_W] == f[4:0])
             || (pin_alt[i*pad_mux_pkg::FN_W +: pad_mux_pkg::FN_W] == f[4:0]))) begin
          periph_in_next[f] = periph_in_next[f] | gated_in[i];
        end
      end
    end
  end

  // ---------------- registered outputs ----------------
  logic [NP-1:0] pad_out_reg, pad_oe_reg, pad_ds_reg, event_reg;
  logic [NF-1:0] periph_in_reg;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pad_out_reg   <= '0;
      pad_oe_reg    <= '0;
      pad_ds_reg    <= '0;
      event_reg     <= '0;
      periph_in_reg <= '0;
    end else begin
      pad_out_reg   <= pad_out_next;
      pad_oe_reg    <= pad_oe_next;
      pad_ds_reg    <= pad_ds_next;
      event_reg     <= gated_in ^ (pol_all & pad_mux_pkg::PIN_PRESENT);
      periph_in_reg <= periph_in_next;
    end
  end

  assign port_b_pins_out        = pad_out_reg[7:0];
  assign port_c_pins_out        = pad_out_reg[15:8];
  assign port_b_pins_oe_out     = pad_oe_reg[7:0];
  assign port_c_pins_oe_out     = pad_oe_reg[15:8];
  assign port_b_drive_level_out = pad_ds_reg[7:0];
  assign port_c_drive_level_out = pad_ds_reg[15:8];
  assign periph_in_out          = periph_in_reg;
  assign pin_event_out          = event_reg;

endmodule

// File: hdl/pad_mux_pkg.sv
package pad_mux_pkg;

  // register indices; byte address is four times the index
  localparam int          REG_IDX_W             = 12;
  localparam int          ADDR_W                = 14;
  localparam int          DATA_W                = 32;
  localparam int          FIELD_W               = 8;
  localparam int          PIN_COUNT             = 16;
  localparam int          PORT_PINS             = 8;
  localparam int          SEL_W                 = 2;
  localparam int          FN_W                  = 5;

  localparam logic [11:0] IDX_PB_INPUT_LEVEL    = 12'h588;
  localparam logic [11:0] IDX_PB_INPUT_GATE     = 12'h589;
  localparam logic [11:0] IDX_PB_OUTPUT_DISABLE = 12'h58a;
  localparam logic [11:0] IDX_PB_OUTPUT_VALUE   = 12'h58b;
  localparam logic [11:0] IDX_PB_POLARITY       = 12'h58c;
  localparam logic [11:0] IDX_PB_DRIVE_LEVEL    = 12'h58d;
  localparam logic [11:0] IDX_PB_GPIO_SELECT    = 12'h58e;
  localparam logic [11:0] IDX_PC_INPUT_LEVEL    = 12'h590;
  localparam logic [11:0] IDX_PC_INPUT_GATE     = 12'h591;
  localparam logic [11:0] IDX_PC_OUTPUT_DISABLE = 12'h592;
  localparam logic [11:0] IDX_PC_OUTPUT_VALUE   = 12'h593;
  localparam logic [11:0] IDX_PC_POLARITY       = 12'h594;
  localparam logic [11:0] IDX_PC_DRIVE_LEVEL    = 12'h595;
  localparam logic [11:0] IDX_PC_GPIO_SELECT    = 12'h596;
  localparam logic [11:0] IDX_PB_LOW_FUNC       = 12'h5aa;
  localparam logic [11:0] IDX_PB_HIGH_FUNC      = 12'h5ab;
  localparam logic [11:0] IDX_PC_LOW_FUNC       = 12'h5ac;
  localparam logic [11:0] IDX_PC_HIGH_FUNC      = 12'h5ad;

  // reset values
  localparam logic [7:0]  RST_PB_INPUT_GATE     = 8'h00;
  localparam logic [7:0]  RST_PC_INPUT_GATE     = 8'hb4;
  localparam logic [7:0]  RST_OUTPUT_DISABLE    = 8'hff;
  localparam logic [7:0]  RST_OUTPUT_VALUE      = 8'h00;
  localparam logic [7:0]  RST_POLARITY          = 8'h00;
  localparam logic [7:0]  RST_DRIVE_LEVEL       = 8'hff;
  localparam logic [7:0]  RST_PB_GPIO_SELECT    = 8'hff;
  localparam logic [7:0]  RST_PC_GPIO_SELECT    = 8'h42;
  localparam logic [7:0]  RST_FUNC_SELECT       = 8'h00;

  // port c pin 0 does not exist
  localparam logic [15:0] PIN_PRESENT           = 16'hfeff;
  localparam int          PIN_C_SLAVE_DATA      = 12;
  localparam int          PIN_C_SLAVE_CLK       = 13;

  // peripheral function codes
  localparam logic [4:0]  FN_PWM_CH0_OUT          = 5'h00;
  localparam logic [4:0]  FN_PWM_CH1_OUT          = 5'h01;
  localparam logic [4:0]  FN_PWM_CH2_OUT          = 5'h02;
  localparam logic [4:0]  FN_PWM_CH3_OUT          = 5'h03;
  localparam logic [4:0]  FN_PWM_CH4_OUT          = 5'h04;
  localparam logic [4:0]  FN_PWM_CH0_INV_OUT      = 5'h05;
  localparam logic [4:0]  FN_PWM_CH1_INV_OUT      = 5'h06;
  localparam logic [4:0]  FN_PWM_CH2_INV_OUT      = 5'h07;
  localparam logic [4:0]  FN_PWM_CH5_INV_OUT      = 5'h08;
  localparam logic [4:0]  FN_SPI_MASTER_DATA_OUT  = 5'h09;
  localparam logic [4:0]  FN_SPI_MASTER_DATA_IN   = 5'h0a;
  localparam logic [4:0]  FN_SPI_MASTER_SERIAL_CLK = 5'h0b;
  localparam logic [4:0]  FN_SPI_MASTER_CHIP_SEL  = 5'h0c;
  localparam logic [4:0]  FN_SPI_SLAVE_CHIP_SEL   = 5'h0d;
  localparam logic [4:0]  FN_SPI_SLAVE_DATA_OUT   = 5'h0e;
  localparam logic [4:0]  FN_SPI_SLAVE_DATA_IN    = 5'h0f;
  localparam logic [4:0]  FN_SPI_SLAVE_SERIAL_CLK = 5'h10;
  localparam logic [4:0]  FN_TWI_MASTER_CLK       = 5'h11;
  localparam logic [4:0]  FN_TWI_MASTER_DATA      = 5'h12;
  localparam logic [4:0]  FN_TWI_SLAVE_DATA       = 5'h13;
  localparam logic [4:0]  FN_TWI_SLAVE_CLK        = 5'h14;
  localparam logic [4:0]  FN_UART_TX              = 5'h15;
  localparam logic [4:0]  FN_UART_RX              = 5'h16;
  localparam logic [4:0]  FN_UART_CTS             = 5'h17;
  localparam logic [4:0]  FN_UART_RTS             = 5'h18;
  localparam logic [4:0]  FN_RADIO_TX_AMP_CYCLE_CTL = 5'h19;
  localparam logic [4:0]  FN_DEBUG_WIRE           = 5'h1a;
  localparam logic [4:0]  FN_NONE                 = 5'h1b;
  localparam int          FN_COUNT                = 27;

  // function per pin and selector value; pins 0..7 port b, 8..15 port c
  localparam logic [4:0] FUNC_MAP [PIN_COUNT][4] = '{
    '{FN_PWM_CH3_OUT, FN_SPI_MASTER_CHIP_SEL, FN_NONE, FN_NONE},
    '{FN_PWM_CH1_OUT, FN_SPI_MASTER_DATA_OUT, FN_RADIO_TX_AMP_CYCLE_CTL, FN_NONE},
    '{FN_PWM_CH2_OUT, FN_SPI_MASTER_DATA_IN, FN_UART_CTS, FN_TWI_MASTER_CLK},
    '{FN_PWM_CH0_OUT, FN_SPI_MASTER_SERIAL_CLK, FN_UART_RTS, FN_TWI_MASTER_DATA},
    '{FN_PWM_CH1_INV_OUT, FN_NONE, FN_UART_TX, FN_NONE},
    '{FN_PWM_CH4_OUT, FN_NONE, FN_UART_RX, FN_NONE},
    '{FN_PWM_CH0_INV_OUT, FN_TWI_MASTER_CLK, FN_UART_RTS, FN_NONE},
    '{FN_PWM_CH1_OUT, FN_TWI_MASTER_DATA, FN_UART_CTS, FN_NONE},
    '{FN_NONE, FN_NONE, FN_NONE, FN_NONE},
    '{FN_PWM_CH2_INV_OUT, FN_NONE, FN_NONE, FN_NONE},
    '{FN_SPI_SLAVE_CHIP_SEL, FN_PWM_CH0_INV_OUT, FN_SPI_MASTER_CHIP_SEL, FN_UART_CTS},
    '{FN_SPI_SLAVE_DATA_OUT, FN_PWM_CH5_INV_OUT, FN_SPI_MASTER_DATA_OUT, FN_UART_RTS},
    '{FN_SPI_SLAVE_DATA_IN, FN_TWI_MASTER_DATA, FN_SPI_MASTER_DATA_IN, FN_UART_TX},
    '{FN_SPI_SLAVE_SERIAL_CLK, FN_TWI_MASTER_CLK, FN_SPI_MASTER_SERIAL_CLK, FN_UART_RX},
    '{FN_PWM_CH4_OUT, FN_NONE, FN_NONE, FN_NONE},
    '{FN_DEBUG_WIRE, FN_PWM_CH3_OUT, FN_NONE, FN_NONE}
  };

endpackage

// File: hdl/level_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser for pad levels
module level_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= level_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign level_out = stage2_reg;

endmodule

// File: test/port_bc_pad_function_mux_monitor.sv
`timescale 1ns/10ps
module pad_mux_monitor (
  input wire logic                             core_clk_in,
  input wire logic                             resetn_in,
  input wire logic                             psel_in,
  input wire logic                             penable_in,
  input wire logic                             pwrite_in,
  input wire logic                             pslverr_out,
  input wire logic [7:0]                       port_b_pins_oe_out,
  input wire logic [7:0]                       port_b_drive_level_out,
  input wire logic [7:0]                       port_c_pins_out,
  input wire logic [7:0]                       port_c_pins_oe_out,
  input wire logic [7:0]                       port_c_drive_level_out,
  input wire logic [pad_mux_pkg::FN_COUNT-1:0] periph_out_in,
  input wire logic [pad_mux_pkg::FN_COUNT-1:0] periph_oe_in,
  input wire logic [15:0]                      pin_event_out
);
  logic [1:0] up_reg;
  logic       cfg_reg;
  // reset setup untouched, past first edges
  wire        quiet = (up_reg == 2'h3) && !cfg_reg;
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      up_reg  <= 2'h0;
      cfg_reg <= 1'b0;
    end else begin
      up_reg  <= (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
      cfg_reg <= cfg_reg | (psel_in & penable_in & pwrite_in);
    end
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  slave_sel_a: assert property (quiet |-> port_c_pins_oe_out[2] == $past(periph_oe_in[13])
    && (!port_c_pins_oe_out[2] || port_c_pins_out[2] == $past(periph_out_in[13])))
    else $error("c2 not following slave select");
  slave_dout_a: assert property (quiet && $rose(port_c_pins_oe_out[3]) |->
    $past(periph_oe_in[14])) else $error("c3 not following slave data out");
  debug_wire_a: assert property (quiet |-> port_c_pins_oe_out[7] == $past(periph_oe_in[26]))
    else $error("c7 not following debug wire");
  gpio_idle_a: assert property (quiet |-> port_b_pins_oe_out == 8'h00
    && (port_c_pins_oe_out & 8'h42) == 8'h00) else $error("released gpio pin drives");
  event_gate_a: assert property (quiet |-> (pin_event_out & 16'h4bff) == 16'h0000)
    else $error("gated pin gives event");
  drive_gate_a: assert property (((port_b_drive_level_out & ~port_b_pins_oe_out)
    | (port_c_drive_level_out & ~port_c_pins_oe_out)) == 8'h00) else $error("drive while off");
  absent_pin_a: assert property (!port_c_pins_oe_out[0]) else $error("c0 drives");
  err_phase_a: assert property (pslverr_out |-> psel_in && penable_in)
    else $error("error outside access");
endmodule
bind port_bc_pad_function_mux pad_mux_monitor i_pad_mux_monitor (.*);

// File: test/pad_loop_model.sv
`timescale 1ns/10ps
module pad_loop_model (
  input  wire logic [7:0] drive_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] ext_in,
  output logic      [7:0] level_out
);
  // released pads show the outside level
  assign level_out = (oe_in & drive_in) | (~oe_in & ext_in);
endmodule

// File: test/test_port_bc_pad_function_mux.sv
`timescale 1ns/10ps
module test_port_bc_pad_function_mux;
  localparam logic [26:0] MASK = 27'h7ffffff;
  // function codes, selector 3..0
  localparam logic [31:0] TBL [16] = '{32'h1b1b0c03, 32'h1b190901, 32'h11170a02,
    32'h12180b00, 32'h1b151b06, 32'h1b161b04, 32'h1b181105, 32'h1b171201, 32'h1b1b1b1b,
    32'h1b1b1b07, 32'h170c050d, 32'h1809080e, 32'h150a120f, 32'h160b1110, 32'h1b1b1b04,
    32'h1b1b031a};
  logic        core_clk_in = 1'b0;
  logic        resetn_in   = 1'b0;
  logic        psel        = 1'b0;
  logic        pen         = 1'b0;
  logic        pwr         = 1'b0;
  logic [13:0] paddr       = 14'h0;
  logic [31:0] pwdata      = 32'h0;
  logic [31:0] seed        = 32'h15728316;
  logic [3:0]  pstrb       = 4'hf;
  logic [7:0]  b_ext       = 8'h00;
  logic [7:0]  c_ext       = 8'h00;
  logic [26:0] p_out       = 27'h0;
  logic [26:0] p_oe        = 27'h0;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic [7:0]  b_lvl, b_out, b_oe, b_dl, c_lvl, c_out, c_oe, c_dl;
  logic [26:0] p_in;
  logic [15:0] ev;
  logic [7:0]  mdl [int];
  int          num_errors  = 0;
  int          n_tests     = 0;
  port_bc_pad_function_mux i_port_bc_pad_function_mux (.core_clk_in(core_clk_in),
    .resetn_in(resetn_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .port_b_pins_in(b_lvl),
    .port_b_pins_out(b_out), .port_b_pins_oe_out(b_oe), .port_b_drive_level_out(b_dl),
    .port_c_pins_in(c_lvl), .port_c_pins_out(c_out), .port_c_pins_oe_out(c_oe),
    .port_c_drive_level_out(c_dl), .periph_out_in(p_out), .periph_oe_in(p_oe),
    .periph_in_out(p_in), .pin_event_out(ev));
  pad_loop_model i_b (.drive_in(b_out), .oe_in(b_oe), .ext_in(b_ext), .level_out(b_lvl));
  pad_loop_model i_c (.drive_in(c_out), .oe_in(c_oe), .ext_in(c_ext), .level_out(c_lvl));
  initial forever #12.5 core_clk_in = ~core_clk_in;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    @(posedge core_clk_in);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    pstrb  <= s;
    @(posedge core_clk_in);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      final_report();
    end
    if (w && s[0] && mdl.exists(idx) && idx != 12'h588 && idx != 12'h590) mdl[idx] = d;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, idx, d, s, rd, er);
  endtask
  task automatic rdchk(input logic [11:0] idx);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, idx, 8'h00, 4'h0, rd, er);
    chk(rd, mdl.exists(idx) ? {24'h0, mdl[idx]} : 32'h0, "read data");
    chk({31'h0, er}, {31'h0, !mdl.exists(idx)}, "slave error");
  endtask
  task automatic pads();
    logic [15:0] eo, dv, ed, lv;
    logic [26:0] pi;
    logic [7:0]  g, sel;
    logic [4:0]  f, a;
    int          p, r;
    pi = '0;
    @(posedge core_clk_in);
    p_out <= 27'(rnd()) & MASK;
    p_oe  <= 27'(rnd()) & MASK;
    b_ext <= 8'(rnd());
    c_ext <= 8'(rnd());
    repeat (4) @(posedge core_clk_in);
    #1;
    lv = {c_lvl, b_lvl};
    for (p = 0; p < 16; p++) begin
      r     = (p / 8) * 8;
      g     = mdl[12'h58e + r];
      sel   = mdl[12'h5aa + p / 4];
      f     = 5'(TBL[p] >> (8 * sel[2 * (p % 4) +: 2]));
      a     = f inside {5'h0f, 5'h10} ? f + 5'h4 : f;
      eo[p] = g[p % 8] ? !mdl[12'h58a + r][p % 8] : (f != 5'h1b && (p_oe[f] || p_oe[a]));
      dv[p] = g[p % 8] ? mdl[12'h58b + r][p % 8] : p_out[f] | p_out[a];
      ed[p] = mdl[12'h58d + r][p % 8];
      if (!g[p % 8] && f != 5'h1b && lv[p] && mdl[12'h589 + r][p % 8]) begin
        pi[f] = 1'b1;
        pi[a] = 1'b1;
      end
    end
    eo[8] = 1'b0;
    chk({c_oe, b_oe}, eo, "pad drive");
    chk({c_out, b_out} & eo, dv & eo, "pad data");
    chk({c_dl, b_dl}, ed & eo, "drive level");
    chk(p_in, pi, "periph input");
  endtask
  initial begin
    for (int r = 0; r < 9; r += 8) begin
      mdl[12'h588 + r]     = 8'h00;
      mdl[12'h58a + r]     = 8'hff;
      mdl[12'h58b + r]     = 8'h00;
      mdl[12'h58c + r]     = 8'h00;
      mdl[12'h58d + r]     = 8'hff;
      mdl[12'h5aa + r / 4] = 8'h00;
      mdl[12'h5ab + r / 4] = 8'h00;
    end
    mdl[12'h589] = pad_mux_pkg::RST_PB_INPUT_GATE;
    mdl[12'h591] = pad_mux_pkg::RST_PC_INPUT_GATE;
    mdl[12'h58e] = 8'hff;
    mdl[12'h596] = 8'h42;
    repeat (10) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    foreach (mdl[k]) rdchk(12'(k));
    rdchk(12'h58f);
    repeat (3) pads();
    wr(12'h58e, 8'h00, 4'hf);
    wr(12'h596, 8'h00, 4'hf);
    for (int v = 0; v < 4; v++) begin
      for (int i = 0; i < 4; i++) wr(12'(12'h5aa + i), 8'(8'h55 * v), 4'hf);
      repeat (2) pads();
    end
    repeat (4) begin
      foreach (mdl[k]) wr(12'(k), 8'(rnd()), 4'(rnd()));
      pads();
      foreach (mdl[k]) if (k != 12'h588 && k != 12'h590) rdchk(12'(k));
    end
    wr(12'h58f, 8'h5a, 4'hf);
    rdchk(12'h58f);
    foreach (mdl[k]) if (k inside {12'h58a, 12'h58e, 12'h592, 12'h596}) wr(12'(k), 8'hff, 4'hf);
    repeat (4) begin
      @(posedge core_clk_in);
      b_ext <= 8'(rnd());
      c_ext <= 8'(rnd()) & 8'hfe;
      for (int k = 0; k < 9; k += 8) wr(12'(12'h589 + k), 8'(rnd()), 4'hf);
      for (int k = 0; k < 9; k += 8) wr(12'(12'h58c + k), 8'(rnd()), 4'hf);
      mdl[12'h588] = b_ext & mdl[12'h589];
      mdl[12'h590] = c_ext & mdl[12'h591];
      wr(12'h588, 8'(rnd()), 4'hf);
      wr(12'h590, 8'(rnd()), 4'hf);
      rdchk(12'h588);
      rdchk(12'h590);
      chk(ev & 16'hfeff, {mdl[12'h590] ^ mdl[12'h594], mdl[12'h588] ^ mdl[12'h58c]} & 16'hfeff,
          "pin event");
    end
    final_report();
  end
endmodule
